//--- pkg/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   localparam logic [7:0] OFS_WEEKDAY  = 8'h06;
   localparam logic [7:0] OFS_ALM_SEC  = 8'h08;
   localparam logic [7:0] OFS_ALM_MIN  = 8'h09;
   localparam logic [7:0] OFS_ALM_HR   = 8'h0A;
   localparam logic [7:0] OFS_ALM_DAY  = 8'h0B;
   localparam logic [7:0] OFS_ALM_MON  = 8'h0C;

   localparam logic [2:0] WEEKDAY_RST  = 3'h0;
   localparam logic [2:0] WEEKDAY_MAX  = 3'h6;
   localparam logic [3:0] UNITS_ONE    = 4'h1;
   localparam logic [3:0] ZERO_DIGIT   = 4'h0;
   localparam logic [7:0] READ_ZERO    = 8'h00;
   localparam logic       FMT_24H      = 1'b0;

   // Live time of day as packed BCD, field layouts as the setpoints
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hr;
      logic [7:0] day;
      logic [7:0] mon;
      logic [7:0] year;
   } time_bcd_t;

   // Register access strobe from the host control bus
   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [2:0] weekday;
      logic [2:0] sec_tens;
      logic [3:0] sec_units;
      logic [2:0] min_tens;
      logic [3:0] min_units;
      logic       pm;
      logic [1:0] hr_tens;
      logic [3:0] hr_units;
      logic [1:0] date_tens;
      logic [3:0] date_units;
      logic       mon_tens;
      logic [3:0] mon_units;
      logic [7:0] rdata;
      logic       alarm_flag;
      logic       alarm_int_n;
      logic       match_prev;
   } alarm_state_t;

endpackage : rtc_alarm_pkg

//--- rtl/rtc_alarm_setpoints.sv
`timescale 1ns/1ps
// Contract
// - Weekday 3-bit field bits 2:0, values 0-6, reset 0, upper bits read zero
// - Seconds setpoint tens in 6:4, units in 3:0, bit 7 reads zero
// - Minutes setpoint tens in 6:4, units in 3:0, bit 7 reads zero
// - Hours setpoint tens in 5:4, units in 3:0, bit 6 reads zero
// - Hours bit 7 is PM flag in 12-hour mode, held 0 in 24-hour
// - Days setpoint tens 5:4, units 3:0 reset to 1, bits 7:6 zero
// - Months setpoint tens bit 4, units reset to 1, bits 7:5 zero
// - Registers return to reset only on the full reset
// - Format select 0 is 24-hour, 1 is 12-hour with PM flag
// - Alarm sets flag and holds interrupt low until software writes 1; code clears on i_alarm_flag_clr input
module rtc_alarm_setpoints
   import rtc_alarm_pkg::*;
(
   // Clock and full reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst,
   // Host register access
   input  wire reg_req_t          i_req,
   output logic [DATA_W-1:0]      o_rdata,
   // Clock core side
   input  wire time_bcd_t         i_live_time,
   input  wire logic [7:0]        i_alarm_year,
   input  wire logic              i_twelve_hour_format,
   input  wire logic              i_alarm_flag_clr,
   output logic                   o_alarm_flag,
   output logic                   o_alarm_int_n
);

   alarm_state_t s_q;
   alarm_state_t s_d;
   logic [7:0]   hr_word;
   logic [7:0]   sp_sec;
   logic [7:0]   sp_min;
   logic [7:0]   sp_day;
   logic [7:0]   sp_mon;
   logic         match;
   logic         fire;

   always_comb begin
      sp_sec = {1'b0, s_q.sec_tens, s_q.sec_units};
      sp_min = {1'b0, s_q.min_tens, s_q.min_units};
      // PM flag only reads back in 12-hour mode, current format applies
      hr_word = {s_q.pm & i_twelve_hour_format, 1'b0,
                 s_q.hr_tens, s_q.hr_units};
      sp_day = {2'b00, s_q.date_tens, s_q.date_units};
      sp_mon = {3'b000, s_q.mon_tens, s_q.mon_units};
   end

   // Match compared in the active hour format; edge-detected so a
   // whole matching second raises one event only
   assign match = (i_live_time.sec == sp_sec) &&
                  (i_live_time.min == sp_min) &&
                  (i_live_time.hr  == hr_word) &&
                  (i_live_time.day == sp_day) &&
                  (i_live_time.mon == sp_mon) &&
                  (i_live_time.year == i_alarm_year);
   assign fire = match && !s_q.match_prev;

   always_comb begin
      s_d = s_q;
      s_d.match_prev = match;
      // Set wins over a clear in the same cycle
      if (fire) begin
         s_d.alarm_flag = 1'b1;
      end else if (i_alarm_flag_clr) begin
         s_d.alarm_flag = 1'b0;
      end
      if (i_req.wr) begin
         if (i_req.addr == OFS_WEEKDAY) begin
            // Out-of-range weekday writes are ignored
            if (i_req.wdata[2:0] <= WEEKDAY_MAX) begin
               s_d.weekday = i_req.wdata[2:0];
            end
         end else if (i_req.addr == OFS_ALM_SEC) begin
            s_d.sec_tens  = i_req.wdata[6:4];
            s_d.sec_units = i_req.wdata[3:0];
         end else if (i_req.addr == OFS_ALM_MIN) begin
            s_d.min_tens  = i_req.wdata[6:4];
            s_d.min_units = i_req.wdata[3:0];
         end else if (i_req.addr == OFS_ALM_HR) begin
            s_d.pm = i_req.wdata[7] & (i_twelve_hour_format != FMT_24H);
            s_d.hr_tens  = i_req.wdata[5:4];
            s_d.hr_units = i_req.wdata[3:0];
         end else if (i_req.addr == OFS_ALM_DAY) begin
            s_d.date_tens  = i_req.wdata[5:4];
            s_d.date_units = i_req.wdata[3:0];
         end else if (i_req.addr == OFS_ALM_MON) begin
            s_d.mon_tens  = i_req.wdata[4];
            s_d.mon_units = i_req.wdata[3:0];
         end
      end
      if (i_req.rd) begin
         if (i_req.addr == OFS_WEEKDAY) begin
            s_d.rdata = {5'b00000, s_q.weekday};
         end else if (i_req.addr == OFS_ALM_SEC) begin
            s_d.rdata = sp_sec;
         end else if (i_req.addr == OFS_ALM_MIN) begin
            s_d.rdata = sp_min;
         end else if (i_req.addr == OFS_ALM_HR) begin
            s_d.rdata = hr_word;
         end else if (i_req.addr == OFS_ALM_DAY) begin
            s_d.rdata = sp_day;
         end else if (i_req.addr == OFS_ALM_MON) begin
            s_d.rdata = sp_mon;
         end else begin
            s_d.rdata = READ_ZERO;
         end
      end
      // Interrupt kept in its own flop so the pin never glitches
      s_d.alarm_int_n = ~s_d.alarm_flag;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         // Only the full reset reaches these registers
         s_q            <= '0;
         s_q.weekday    <= WEEKDAY_RST;
         s_q.date_units <= UNITS_ONE;
         s_q.mon_units  <= UNITS_ONE;
         s_q.rdata      <= READ_ZERO;
         s_q.alarm_int_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata       = s_q.rdata;
   assign o_alarm_flag  = s_q.alarm_flag;
   assign o_alarm_int_n = s_q.alarm_int_n;

   a_reset_values: assert property (@(posedge i_ref_clk)
      $past(i_rst) && !i_rst |-> s_q.date_units == UNITS_ONE &&
         s_q.mon_units == UNITS_ONE && s_q.weekday == WEEKDAY_RST)
      else $error("setpoint reset values wrong");

   a_weekday_range: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_q.weekday <= WEEKDAY_MAX)
      else $error("weekday out of range");

   a_alarm_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      fire |=> o_alarm_flag && !o_alarm_int_n)
      else $error("alarm did not set flag");

   a_flag_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_alarm_flag && !i_alarm_flag_clr |=> o_alarm_flag)
      else $error("alarm flag dropped without clear");

   a_flag_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_alarm_flag_clr && !fire |=> !o_alarm_flag && o_alarm_int_n)
      else $error("alarm flag not cleared");

   a_pm_24h: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr == OFS_ALM_HR && !i_twelve_hour_format
      |=> !o_rdata[7] && !o_rdata[6])
      else $error("PM bit visible in 24-hour mode");

   a_sec_rdback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.wr && i_req.addr == OFS_ALM_SEC ##1
      i_req.rd && !i_req.wr && i_req.addr == OFS_ALM_SEC
      |=> o_rdata == {1'b0, $past(i_req.wdata[6:0], 2)})
      else $error("seconds setpoint readback wrong");

   a_mon_reserved: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr == OFS_ALM_MON |=> o_rdata[7:5] == 3'h0)
      else $error("months reserved bits nonzero");

   a_day_reserved: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr == OFS_ALM_DAY |=> o_rdata[7:6] == 2'h0)
      else $error("days reserved bits nonzero");

   a_sec_reserved: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr == OFS_ALM_SEC |=> !o_rdata[7])
      else $error("seconds reserved bit nonzero");

   a_min_reserved: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr == OFS_ALM_MIN |=> !o_rdata[7])
      else $error("minutes reserved bit nonzero");

   a_hr_reserved: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr == OFS_ALM_HR |=> !o_rdata[6])
      else $error("hours reserved bit nonzero");

   a_wkday_reserved: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr == OFS_WEEKDAY
      |=> o_rdata[7:3] == READ_ZERO[7:3])
      else $error("weekday reserved bits nonzero");

   a_int_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_alarm_int_n == !o_alarm_flag)
      else $error("interrupt does not follow flag");

   a_no_refire: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !o_alarm_flag && match && s_q.match_prev |=> !o_alarm_flag)
      else $error("held match fired again");

   a_rdata_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_req.rd |=> $stable(o_rdata))
      else $error("read data changed without read");

   a_pm_write_24h: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.wr && i_req.addr == OFS_ALM_HR && !i_twelve_hour_format
      |=> !s_q.pm)
      else $error("PM bit stored in 24-hour mode");

   a_unmapped_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req.rd && i_req.addr != OFS_WEEKDAY && i_req.addr != OFS_ALM_SEC &&
      i_req.addr != OFS_ALM_MIN && i_req.addr != OFS_ALM_HR &&
      i_req.addr != OFS_ALM_DAY && i_req.addr != OFS_ALM_MON
      |=> o_rdata == READ_ZERO)
      else $error("unmapped read not zero");

endmodule : rtc_alarm_setpoints

//--- sim/rtc_alarm_setpoints_tb_top.sv
`timescale 1ns/1ps
module rtc_alarm_setpoints_tb_top;
   import rtc_alarm_pkg::*;

   logic              i_ref_clk   = 1'b0;
   logic              i_rst       = 1'b1;
   reg_req_t          req         = '0;
   time_bcd_t         live        = '0;
   logic [7:0]        year        = 8'h00;
   logic              fmt         = 1'b0;
   logic              clr         = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              flag;
   logic              int_n;
   logic              rd_d        = 1'b0;
   logic              wv, rv;
   logic [7:0]        mdl [16];
   logic [7:0]        exp_q [$];
   int                error_cnt   = 0;
   int                check_count = 0;
   int                cyc         = 0;

   always #2.5 i_ref_clk = ~i_ref_clk;

   rtc_alarm_setpoints dut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
      .i_live_time(live), .i_alarm_year(year), .i_twelve_hour_format(fmt),
      .i_alarm_flag_clr(clr), .o_alarm_flag(flag), .o_alarm_int_n(int_n));

   task automatic check(input string nm, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // Writable bits per offset; anything unmapped reads zero
   function automatic logic [7:0] msk(input logic [7:0] a);
      case (a)
         OFS_WEEKDAY:              msk = 8'h07;
         OFS_ALM_SEC, OFS_ALM_MIN: msk = 8'h7f;
         OFS_ALM_HR:               msk = (fmt == FMT_24H) ? 8'h3f : 8'hbf;
         OFS_ALM_DAY:              msk = 8'h3f;
         OFS_ALM_MON:              msk = 8'h1f;
         default:                  msk = 8'h00;
      endcase
   endfunction : msk

   // Read note is taken first, so a same-cycle write shows the old value
   task automatic acc(input logic w, r, input logic [7:0] a, d);
      @(posedge i_ref_clk);
      req <= '{wr: w, rd: r, addr: a, wdata: d};
      if (r) exp_q.push_back(mdl[a[3:0]] & msk(a));
      if (w && !(a == OFS_WEEKDAY && d[2:0] == 3'h7)) mdl[a[3:0]] = d & msk(a);
      @(posedge i_ref_clk);
      req <= '0;
   endtask : acc

   task automatic read_all();
      for (int k = 6; k <= 13; k++) acc(1'b0, 1'b1, 8'(k), 8'h00);
   endtask : read_all

   task automatic do_reset();
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      foreach (mdl[k]) mdl[k] = 8'h00;
      mdl[11] = 8'h01;
      mdl[12] = 8'h01;
   endtask : do_reset

   task automatic report_and_stop();
      if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // Read data lands one edge after the strobe is taken
   always @(posedge i_ref_clk) rd_d <= req.rd;
   always @(negedge i_ref_clk) begin
      if (rd_d && exp_q.size() > 0) check("o_rdata", rdata, exp_q.pop_front());
   end

   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      void'($urandom(32'h95e1_18ae));
      do_reset();
      read_all();
      for (int k = 6; k <= 12; k++) acc(1'b1, 1'b0, 8'(k), 8'hff);
      read_all();
      acc(1'b1, 1'b1, OFS_WEEKDAY, 8'h06);
      @(posedge i_ref_clk) fmt <= 1'b1;
      acc(1'b1, 1'b0, OFS_ALM_HR, 8'hff);
      acc(1'b0, 1'b1, OFS_ALM_HR, 8'h00);
      @(posedge i_ref_clk) fmt <= 1'b0;
      acc(1'b0, 1'b1, OFS_ALM_HR, 8'h00);
      repeat (200) begin
         wv = 1'($urandom);
         rv = 1'($urandom);
         @(posedge i_ref_clk) fmt <= 1'($urandom);
         acc(wv, rv, 8'h06 + 8'($urandom % 8), 8'($urandom));
      end
      @(posedge i_ref_clk) fmt <= 1'b0;
      acc(1'b1, 1'b0, OFS_ALM_SEC, 8'h30);
      acc(1'b1, 1'b0, OFS_ALM_MIN, 8'h15);
      acc(1'b1, 1'b0, OFS_ALM_HR, 8'h12);
      acc(1'b1, 1'b0, OFS_ALM_DAY, 8'h25);
      acc(1'b1, 1'b0, OFS_ALM_MON, 8'h11);
      // Drop any flag left by an accidental match in the random phase
      @(posedge i_ref_clk) clr <= 1'b1;
      @(posedge i_ref_clk) clr <= 1'b0;
      @(negedge i_ref_clk);
      check("o_alarm_flag", {7'h00, flag}, 8'h00);
      @(posedge i_ref_clk) begin
         year <= 8'h24;
         live <= '{8'h30, 8'h15, 8'h12, 8'h25, 8'h11, 8'h24};
      end
      for (int k = 0; k < 3 && flag !== 1'b1; k++) @(negedge i_ref_clk);
      check("o_alarm_flag", {7'h00, flag}, 8'h01);
      check("o_alarm_int_n", {7'h00, int_n}, 8'h00);
      @(posedge i_ref_clk) clr <= 1'b1;
      @(posedge i_ref_clk) clr <= 1'b0;
      repeat (4) @(negedge i_ref_clk);
      // Match still holds, so a re-fire would show here
      check("o_alarm_flag", {7'h00, flag}, 8'h00);
      check("o_alarm_int_n", {7'h00, int_n}, 8'h01);
      do_reset();
      read_all();
      repeat (3) @(posedge i_ref_clk);
      check("read notes left", 8'(exp_q.size()), 8'h00);
      report_and_stop();
   end

endmodule : rtc_alarm_setpoints_tb_top
